// file: design/ltmc_top.sv
// Register bank and monitor routing for the loop-through monitor output
`timescale 1ns/100ps
`default_nettype none
module ltmc_top
    import ltmc_pkg::*;
#(
    parameter int ADR_W = 9
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ADR_W-1:0]              wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [ltmc_pkg::BUS_DATA_W-1:0] wb_dat_i,
    output var  logic [ltmc_pkg::BUS_DATA_W-1:0] wb_dat_o,
    output var  logic                          wb_ack_o,
    input  wire logic                          link_input_port0,
    input  wire logic                          link_input_port1,
    output var  logic                          loop_through_monitor_output,
    output var  logic                          monitor_tx_powerdown,
    output var  logic                          test_pattern_enable,
    output var  logic                          monitor_port_select_single
);
    import ltmc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]  selectSingle_reg;
    logic [7:0]  driverEnable_reg;
    logic [7:0]  monitorRoute_reg;
    logic [7:0]  txPower_reg;
    logic [7:0]  testPattern_reg;
    logic        ackNext;
    logic        wrStrobe;
    logic        wrLane0;
    logic [6:0]  regIndex;
    logic        hitSingle;
    logic        hitEnable;
    logic        hitRoute;
    logic        hitPower;
    logic        hitPattern;
    logic        hitStatus;
    logic [7:0]  readByte;
    logic [7:0]  statusByte;
    logic [1:0]  linkSync;
    logic        monitorActive;
    logic [1:0]  portSelectPair;
    logic        portSelectMismatch;
    logic        patternOrderFault;

    // Keeps only the defined bits of a written byte
    function automatic logic [7:0] ltmc_mask_write(input logic [7:0] data, input int pos,
                                                   input int width);
        logic [7:0] mask;
        mask = 8'h00;
        for (int i = 0; i < 8; i++)
            if (i >= pos && i < pos + width)
                mask[i] = 1'b1;
        return data & mask;
    endfunction : ltmc_mask_write

    // ****************************************************************
    // Wishbone decode
    // ****************************************************************
    assign regIndex   = wb_adr_i[8:2];
    assign ackNext    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A write lands on the edge where the master sees ack
    assign wrStrobe   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wrLane0    = wrStrobe && wb_sel_i[0];
    assign hitSingle  = (regIndex == IDX_PORT_SELECT_SINGLE);
    assign hitEnable  = (regIndex == IDX_DRIVER_ENABLE);
    assign hitRoute   = (regIndex == IDX_MONITOR_ROUTE);
    assign hitPower   = (regIndex == IDX_MONITOR_TX_POWER);
    assign hitPattern = (regIndex == IDX_TEST_PATTERN);
    assign hitStatus  = (regIndex == IDX_MONITOR_STATUS);

    // ****************************************************************
    // Status and read mux
    // ****************************************************************
    assign portSelectPair     = monitorRoute_reg[POS_PAIR_LO+1:POS_PAIR_LO];
    // Flags software that broke the pairing of the two select fields
    assign portSelectMismatch = !((selectSingle_reg[POS_SELECT_SINGLE] == 1'b0 &&
                                   portSelectPair == PAIR_PORT0) ||
                                  (selectSingle_reg[POS_SELECT_SINGLE] == 1'b1 &&
                                   portSelectPair == PAIR_PORT1));
    // Flags the generator running with the monitor transmitter still powered
    assign patternOrderFault  = testPattern_reg[POS_PATTERN_ENABLE] &&
                                !txPower_reg[POS_TX_POWERDOWN];
    assign statusByte = {4'h0, patternOrderFault, portSelectMismatch,
                         selectSingle_reg[POS_SELECT_SINGLE], monitorActive};
    assign readByte   = hitSingle  ? selectSingle_reg :
                        hitEnable  ? driverEnable_reg :
                        hitRoute   ? monitorRoute_reg :
                        hitPower   ? txPower_reg      :
                        hitPattern ? testPattern_reg  :
                        hitStatus  ? statusByte       : 8'h00;

    // ****************************************************************
    // Bus answer: ack one cycle after the request, dropped next cycle
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= ackNext;
            wb_dat_o <= ackNext ? {24'h000000, readByte} : '0;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            selectSingle_reg <= RST_SELECT_SINGLE;
            driverEnable_reg <= RST_DRIVER_ENABLE;
            monitorRoute_reg <= RST_MONITOR_ROUTE;
            txPower_reg      <= RST_TX_POWER;
            testPattern_reg  <= RST_TEST_PATTERN;
        end
        else if (wrLane0)
        begin
            if (hitSingle)
                selectSingle_reg <= ltmc_mask_write(wb_dat_i[7:0], POS_SELECT_SINGLE, 1);
            if (hitEnable)
                driverEnable_reg <= ltmc_mask_write(wb_dat_i[7:0], POS_DRIVER_ENABLE, 1);
            if (hitRoute)
                monitorRoute_reg <= ltmc_mask_write(wb_dat_i[7:0], POS_PAIR_LO, 2);
            if (hitPower)
                txPower_reg <= ltmc_mask_write(wb_dat_i[7:0], POS_TX_POWERDOWN, 1);
            if (hitPattern)
                testPattern_reg <= wb_dat_i[7:0];
        end
    end

    // ****************************************************************
    // Control outputs, each from a flop
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            monitor_tx_powerdown       <= 1'b0;
            test_pattern_enable        <= 1'b0;
            monitor_port_select_single <= 1'b0;
        end
        else
        begin
            monitor_tx_powerdown       <= txPower_reg[POS_TX_POWERDOWN];
            test_pattern_enable        <= testPattern_reg[POS_PATTERN_ENABLE];
            monitor_port_select_single <= selectSingle_reg[POS_SELECT_SINGLE];
        end
    end

    // ****************************************************************
    // Link input synchroniser and monitor driver
    // ****************************************************************
    ltmc_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn ({link_input_port1, link_input_port0}),
        .syncOut (linkSync)
    );

    ltmc_monitor_drive u_drive (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .portSelectPair (portSelectPair),
        .driverEnable   (driverEnable_reg[POS_DRIVER_ENABLE]),
        .txPowerDown    (monitor_tx_powerdown),
        .port0Data      (linkSync[0]),
        .port1Data      (linkSync[1]),
        .monitorOut     (loop_through_monitor_output),
        .monitorActive  (monitorActive)
    );

    initial
    begin
        if (ADR_W < ADR_W_MIN)
            $error("ltmc_top: ADR_W too small for the register map");
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_route_port0;
        @(posedge ref_clk) disable iff (rst)
        (driverEnable_reg[POS_DRIVER_ENABLE] && !monitor_tx_powerdown &&
         portSelectPair == PAIR_PORT0)
        |=> (loop_through_monitor_output == $past(linkSync[0]));
    endproperty
    a_route_port0: assert property (p_route_port0)
        else $error("monitor output does not follow port 0");

    property p_route_port1;
        @(posedge ref_clk) disable iff (rst)
        (driverEnable_reg[POS_DRIVER_ENABLE] && !monitor_tx_powerdown &&
         portSelectPair == PAIR_PORT1)
        |=> (loop_through_monitor_output == $past(linkSync[1]));
    endproperty
    a_route_port1: assert property (p_route_port1)
        else $error("monitor output does not follow port 1");

    property p_driver_off_idle;
        @(posedge ref_clk) disable iff (rst)
        !driverEnable_reg[POS_DRIVER_ENABLE] |=> !loop_through_monitor_output && !monitorActive;
    endproperty
    a_driver_off_idle: assert property (p_driver_off_idle)
        else $error("monitor output driven while driver disabled");

    property p_powerdown_write;
        @(posedge ref_clk) disable iff (rst)
        (wrLane0 && hitPower)
        |=> ##1 (monitor_tx_powerdown == $past(wb_dat_i[POS_TX_POWERDOWN], 2));
    endproperty
    a_powerdown_write: assert property (p_powerdown_write)
        else $error("power-down output does not follow its written bit");

    property p_powered_down_idle;
        @(posedge ref_clk) disable iff (rst)
        monitor_tx_powerdown |=> !monitorActive;
    endproperty
    a_powered_down_idle: assert property (p_powered_down_idle)
        else $error("monitor active while transmitter powered down");

    property p_enable_reset;
        @(posedge ref_clk) disable iff (rst)
        $past(rst) |-> !driverEnable_reg[POS_DRIVER_ENABLE] && !loop_through_monitor_output;
    endproperty
    a_enable_reset: assert property (p_enable_reset)
        else $error("driver enable not clear after reset");

    property p_single_select;
        @(posedge ref_clk) disable iff (rst)
        (wrLane0 && hitSingle)
        |=> ##1 (monitor_port_select_single == $past(wb_dat_i[POS_SELECT_SINGLE], 2));
    endproperty
    a_single_select: assert property (p_single_select)
        else $error("single select output does not follow its written bit");

    property p_pattern_enable;
        @(posedge ref_clk) disable iff (rst)
        (wrLane0 && hitPattern)
        |=> ##1 (test_pattern_enable == $past(wb_dat_i[POS_PATTERN_ENABLE], 2));
    endproperty
    a_pattern_enable: assert property (p_pattern_enable)
        else $error("pattern enable output does not follow its written bit");

    property p_undefined_pair_idle;
        @(posedge ref_clk) disable iff (rst)
        (portSelectPair == 2'h0 || portSelectPair == 2'h3)
        |=> !loop_through_monitor_output && !monitorActive;
    endproperty
    a_undefined_pair_idle: assert property (p_undefined_pair_idle)
        else $error("monitor output not idle for undefined pair select");

    property p_ack_single;
        @(posedge ref_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack held for more than one cycle");

    property p_ack_answer;
        @(posedge ref_clk) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not answered in the next cycle");

    property p_read_data_idle;
        @(posedge ref_clk) disable iff (rst)
        !wb_ack_o |-> (wb_dat_o == '0);
    endproperty
    a_read_data_idle: assert property (p_read_data_idle)
        else $error("read data not zero outside the ack cycle");

    property p_enable_write;
        @(posedge ref_clk) disable iff (rst)
        (wrLane0 && hitEnable)
        |=> (driverEnable_reg[POS_DRIVER_ENABLE] == $past(wb_dat_i[POS_DRIVER_ENABLE]));
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("driver enable bit does not take its written value");

endmodule : ltmc_top
`default_nettype wire

// file: design/ltmc_pkg.sv
// Package of register map, field positions and reset values for the loop-through monitor control
package ltmc_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [6:0] IDX_PORT_SELECT_SINGLE = 7'h52;
    localparam logic [6:0] IDX_DRIVER_ENABLE      = 7'h56;
    localparam logic [6:0] IDX_MONITOR_ROUTE      = 7'h57;
    localparam logic [6:0] IDX_MONITOR_TX_POWER   = 7'h63;
    localparam logic [6:0] IDX_TEST_PATTERN       = 7'h64;
    localparam logic [6:0] IDX_MONITOR_STATUS     = 7'h66;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int POS_SELECT_SINGLE   = 7;
    localparam int POS_DRIVER_ENABLE   = 3;
    localparam int POS_PAIR_LO         = 1;
    localparam int POS_TX_POWERDOWN    = 0;
    localparam int POS_PATTERN_ENABLE  = 0;
    localparam int POS_STAT_ACTIVE     = 0;
    localparam int POS_STAT_PORT1      = 1;
    localparam int POS_STAT_MISMATCH   = 2;
    localparam int POS_STAT_ORDER      = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_SELECT_SINGLE = 8'h00;
    localparam logic [7:0] RST_DRIVER_ENABLE = 8'h00;
    localparam logic [7:0] RST_MONITOR_ROUTE = 8'h00;
    localparam logic [7:0] RST_TX_POWER      = 8'h00;
    localparam logic [7:0] RST_TEST_PATTERN  = 8'h10;

    // ****************************************************************
    // Monitor port select pair codes
    // ****************************************************************
    localparam logic [1:0] PAIR_PORT0 = 2'h1;
    localparam logic [1:0] PAIR_PORT1 = 2'h2;

    // Bus geometry
    localparam int BUS_DATA_W = 32;
    localparam int ADR_W_MIN  = 9;

endpackage : ltmc_pkg

// file: design/ltmc_sync2.sv
// Two-flop synchroniser for link inputs arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module ltmc_sync2 #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    // ****************************************************************
    // Synchroniser chain; first stage feeds only the second
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end

    initial
    begin
        if (WIDTH < 1)
            $error("ltmc_sync2: WIDTH must be at least 1");
    end
endmodule : ltmc_sync2
`default_nettype wire

// file: design/ltmc_monitor_drive.sv
// Monitor output selector and driver gate for the loop-through path
`timescale 1ns/100ps
`default_nettype none
module ltmc_monitor_drive
    import ltmc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [1:0] portSelectPair,
    input  wire logic       driverEnable,
    input  wire logic       txPowerDown,
    input  wire logic       port0Data,
    input  wire logic       port1Data,
    output var  logic       monitorOut,
    output var  logic       monitorActive
);
    logic selPort0;
    logic selPort1;
    logic driveOn;
    logic monitorNext;

    // Decode of the pair field; 00 and 11 select nothing
    assign selPort0    = (portSelectPair == PAIR_PORT0);
    assign selPort1    = (portSelectPair == PAIR_PORT1);
    // Driver only runs when enabled and the transmitter is powered
    assign driveOn     = driverEnable && !txPowerDown;
    assign monitorNext = driveOn && ((selPort0 && port0Data) || (selPort1 && port1Data));

    // ****************************************************************
    // Output flops; idle level is low
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            monitorOut    <= 1'b0;
            monitorActive <= 1'b0;
        end
        else
        begin
            monitorOut    <= monitorNext;
            monitorActive <= driveOn && (selPort0 || selPort1);
        end
    end
endmodule : ltmc_monitor_drive
`default_nettype wire

// file: dv/ltmc_tb.sv
// Self-checking testbench for the loop-through monitor control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ltmc_pkg::*;

    // ****************************************************************
    // Stimulus signals and counters
    // ****************************************************************
    logic        refClk = 1'b0;
    logic        rstIn  = 1'b1;
    logic        wbCyc  = 1'b0;
    logic        wbStb  = 1'b0;
    logic        wbWe   = 1'b0;
    logic [8:0]  wbAdr  = 9'h000;
    logic [3:0]  wbSel  = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        port0  = 1'b0;
    logic        port1  = 1'b0;
    logic        monOut;
    logic        txPwdn;
    logic        patEn;
    logic        selSingle;
    int          errors    = 0;
    int          cmp_count = 0;

    // Clock of 20 ns period
    always #10 refClk = ~refClk;

    ltmc_top #(.ADR_W(9)) ltmc_top_i (
        .ref_clk                    (refClk),
        .rst                        (rstIn),
        .wb_cyc_i                   (wbCyc),
        .wb_stb_i                   (wbStb),
        .wb_we_i                    (wbWe),
        .wb_adr_i                   (wbAdr),
        .wb_sel_i                   (wbSel),
        .wb_dat_i                   (wbDatI),
        .wb_dat_o                   (wbDatO),
        .wb_ack_o                   (wbAck),
        .link_input_port0           (port0),
        .link_input_port1           (port1),
        .loop_through_monitor_output(monOut),
        .monitor_tx_powerdown       (txPwdn),
        .test_pattern_enable        (patEn),
        .monitor_port_select_single (selSingle)
    );

    // ****************************************************************
    // Helper tasks
    // ****************************************************************
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Compares one value and reports a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic single cycle; holds the request until ack is sampled
    task automatic wb_xfer(input logic we, input logic [6:0] idx, input logic [7:0] wd,
                           input logic [3:0] sel, output logic [31:0] rd);
        @(posedge refClk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= {idx, 2'h0};
        wbSel  <= sel;
        wbDatI <= {24'h0, wd};
        do
        begin
            @(posedge refClk);
        end while (wbAck !== 1'b1);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        wb_xfer(1'b1, idx, wd, 4'hf, d);
    endtask : wr

    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, idx, 8'h00, 4'hf, d);
        chk(d, {24'h0, exp});
    endtask : rd_chk

    // Drives both ports with opposite data and checks the monitor output
    task automatic route_chk(input logic [1:0] expSel);
        logic v;
        for (int k = 0; k < 2; k++)
        begin
            v = k[0];
            @(posedge refClk);
            port0 <= v;
            port1 <= ~v;
            repeat (5) @(posedge refClk);
            #1;
            chk({31'h0, monOut}, {31'h0, expSel == 2'h1 ? v : expSel == 2'h2 ? ~v : 1'b0});
        end
    endtask : route_chk

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    logic [6:0] idxTab [5] = '{7'h52, 7'h56, 7'h57, 7'h63, 7'h64};
    logic [7:0] rstTab [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10};
    logic [7:0] mskTab [5] = '{8'h80, 8'h08, 8'h06, 8'h01, 8'hff};

    // Reset values, writable bits, unmapped place and ignored byte lane
    task automatic sc_registers;
        logic [31:0] d;
        for (int i = 0; i < 5; i++)
            rd_chk(idxTab[i], rstTab[i]);
        chk({29'h0, txPwdn, patEn, selSingle}, 32'h0);
        for (int i = 0; i < 5; i++)
            wr(idxTab[i], 8'hff);
        for (int i = 0; i < 5; i++)
            rd_chk(idxTab[i], mskTab[i]);
        repeat (3) @(posedge refClk);
        chk({29'h0, txPwdn, patEn, selSingle}, 32'h7);
        for (int i = 4; i >= 0; i--)
            wr(idxTab[i], rstTab[i]);
        repeat (3) @(posedge refClk);
        chk({29'h0, txPwdn, patEn, selSingle}, 32'h0);
        wb_xfer(1'b1, 7'h56, 8'hff, 4'he, d);
        rd_chk(7'h56, 8'h00);
        wr(7'h70, 8'hff);
        rd_chk(7'h70, 8'h00);
    endtask : sc_registers

    // Every pair code, then driver enable and power-down gating
    task automatic sc_routing;
        wr(7'h56, 8'h08);
        for (int c = 0; c < 4; c++)
        begin
            wr(7'h52, c == 2 ? 8'h80 : 8'h00);
            wr(7'h57, {5'h0, c[1:0], 1'b0});
            route_chk(c[1:0]);
        end
        wr(7'h52, 8'h00);
        wr(7'h57, 8'h02);
        wr(7'h56, 8'h00);
        route_chk(2'h0);
        wr(7'h56, 8'h08);
        route_chk(2'h1);
        wr(7'h63, 8'h01);
        route_chk(2'h0);
        wr(7'h63, 8'h00);
        route_chk(2'h1);
    endtask : sc_routing

    // Latency of three edges from port 0 to the monitor output
    task automatic sc_latency;
        @(posedge refClk);
        port0 <= 1'b0;
        repeat (5) @(posedge refClk);
        port0 <= 1'b1;
        repeat (2) @(posedge refClk);
        #1;
        chk({31'h0, monOut}, 32'h0);
        @(posedge refClk);
        #1;
        chk({31'h0, monOut}, 32'h1);
    endtask : sc_latency

    // Status flags: monitor active, single select copy and pairing mismatch
    task automatic sc_status;
        rd_chk(7'h66, 8'h01);
        wr(7'h52, 8'h80);
        rd_chk(7'h66, 8'h07);
        wr(7'h57, 8'h04);
        rd_chk(7'h66, 8'h03);
        wr(7'h57, 8'h02);
        wr(7'h52, 8'h00);
        rd_chk(7'h66, 8'h01);
    endtask : sc_status

    // Pattern generator enabled only after the transmitter is powered down
    task automatic sc_pattern;
        wr(7'h63, 8'h01);
        wr(7'h64, 8'h11);
        repeat (3) @(posedge refClk);
        chk({30'h0, txPwdn, patEn}, 32'h3);
        rd_chk(7'h64, 8'h11);
        rd_chk(7'h66, 8'h00);
        wr(7'h64, 8'h10);
        repeat (3) @(posedge refClk);
        chk({31'h0, patEn}, 32'h0);
    endtask : sc_pattern

    // Reset in mid-run returns every register and output to its reset value
    task automatic sc_midreset;
        @(posedge refClk);
        rstIn <= 1'b1;
        repeat (2) @(posedge refClk);
        chk({30'h0, wbAck, txPwdn}, 32'h0);
        rstIn <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd_chk(idxTab[i], rstTab[i]);
        rd_chk(7'h66, 8'h04);
        chk({29'h0, txPwdn, patEn, monOut}, 32'h0);
    endtask : sc_midreset

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge refClk);
        rstIn <= 1'b0;
        sc_registers;
        sc_routing;
        sc_latency;
        sc_status;
        sc_pattern;
        sc_midreset;
        end_of_test;
    end

    initial
    begin
        repeat (20000) @(posedge refClk);
        errors++;
        end_of_test;
    end

endmodule : testbench
`default_nettype wire
